//--- hw/lsc_map.svh
// Constants for the load step controller: counts, field widths, reset values.
// Assumes nothing; included by the package and the design files.
`ifndef LSC_MAP_SVH
`define LSC_MAP_SVH

// ****************************************************************
// Sizes
// ****************************************************************
`define LSC_MAX_STEPS 5
`define LSC_KW_W 16
`define LSC_DLY_W 32
`define LSC_CNT_W 3

// ****************************************************************
// Register map
// ****************************************************************
`define LSC_A_CTRL 8'h00
`define LSC_A_BAL_TRIP 8'h04
`define LSC_A_BAL_RET 8'h08
`define LSC_A_BAL_TDLY 8'h0c
`define LSC_A_BAL_RDLY 8'h10
`define LSC_A_SHD_TRIP 8'h14
`define LSC_A_SHD_RET 8'h18
`define LSC_A_SHD_TDLY 8'h1c
`define LSC_A_SHD_RDLY 8'h20
`define LSC_A_STATUS 8'h24

// Control register fields
`define LSC_CTRL_BAL_CNT_LSB 0
`define LSC_CTRL_SHD_CNT_LSB 4
`define LSC_CTRL_INIT_CNT_LSB 8

// Status register fields
`define LSC_ST_BAL_LSB 0
`define LSC_ST_SHD_LSB 8
`define LSC_ST_ON_LOAD_BIT 16

// ****************************************************************
// Reset values
// ****************************************************************
`define LSC_RST_CNT 3'h0
`define LSC_RST_KW 16'h0000
`define LSC_RST_DLY 32'h0000_0001

`endif

//--- hw/lsc_pkg.sv
// Types for the load step controller.
// Assumes lsc_map.svh is on the include path.
`include "lsc_map.svh"

package lsc_pkg;

	// ****************************************************************
	// Step group direction
	// ****************************************************************
	typedef enum logic [1:0] {
		LSC_IDLE,
		LSC_TRIP,
		LSC_RET
	} lsc_tmr_t;

	typedef logic [`LSC_KW_W-1:0] lsc_kw_t;
	typedef logic [`LSC_DLY_W-1:0] lsc_dly_t;
	typedef logic [`LSC_CNT_W-1:0] lsc_cnt_t;

endpackage : lsc_pkg

//--- hw/lsc_step_if.sv
// Carrier between the controller top and one step sequencer.
// Assumes a single clock shared by both ends.
`timescale 1ns/1ps

interface lsc_step_if;
	import lsc_pkg::*;
	logic run;
	logic clear;
	logic preset;
	lsc_cnt_t preset_cnt;
	lsc_cnt_t max_cnt;
	logic trip_cond;
	logic ret_cond;
	lsc_dly_t trip_dly;
	lsc_dly_t ret_dly;
	lsc_cnt_t level;

	modport ctrl (
		output run,
		output clear,
		output preset,
		output preset_cnt,
		output max_cnt,
		output trip_cond,
		output ret_cond,
		output trip_dly,
		output ret_dly,
		input level
	);
	modport seq (
		input run,
		input clear,
		input preset,
		input preset_cnt,
		input max_cnt,
		input trip_cond,
		input ret_cond,
		input trip_dly,
		input ret_dly,
		output level
	);
endinterface : lsc_step_if

//--- hw/lsc_step_seq.sv
// One step sequencer: a count of energised steps raised after the trip
// delay and lowered after the return delay.
// Assumes conditions are synchronous to clk_sys.
`timescale 1ns/1ps
`include "lsc_map.svh"

module lsc_step_seq
	import lsc_pkg::*;
(
	input wire logic clk_sys,
	input wire logic rst,
	lsc_step_if.seq s
);

	typedef struct packed {
		lsc_tmr_t mode;
		lsc_dly_t tmr;
		lsc_cnt_t level;
	} lsc_seq_st_t;

	lsc_seq_st_t st_q;
	lsc_seq_st_t st_d;

	assign s.level = st_q.level;

	// ****************************************************************
	// Next state
	// ****************************************************************
	always_comb
	begin
		st_d = st_q;
		if (s.clear)
		begin
			st_d.mode = LSC_IDLE;
			st_d.tmr = '0;
			st_d.level = `LSC_RST_CNT;
		end
		else if (s.preset)
		begin
			st_d.mode = LSC_IDLE;
			st_d.tmr = '0;
			st_d.level = (s.preset_cnt > s.max_cnt) ? s.max_cnt : s.preset_cnt;
		end
		else if (!s.run)
		begin
			st_d.mode = LSC_IDLE;
			st_d.tmr = '0;
		end
		else
		begin
			case (st_q.mode)
				LSC_IDLE:
				begin
					st_d.tmr = '0;
					if (s.trip_cond && st_q.level < s.max_cnt)
						st_d.mode = LSC_TRIP;
					else if (s.ret_cond && st_q.level != '0)
						st_d.mode = LSC_RET;
				end
				LSC_TRIP:
				begin
					if (!s.trip_cond || st_q.level >= s.max_cnt)
					begin
						st_d.mode = LSC_IDLE;
						st_d.tmr = '0;
					end
					else if (st_q.tmr + 32'h1 >= s.trip_dly)
					begin
						// Restart the delay so each full period adds a step
						st_d.level = st_q.level + 3'h1;
						st_d.tmr = '0;
					end
					else
						st_d.tmr = st_q.tmr + 32'h1;
				end
				LSC_RET:
				begin
					if (!s.ret_cond || st_q.level == '0)
					begin
						st_d.mode = LSC_IDLE;
						st_d.tmr = '0;
					end
					else if (st_q.tmr + 32'h1 >= s.ret_dly)
					begin
						st_d.level = st_q.level - 3'h1;
						st_d.tmr = '0;
					end
					else
						st_d.tmr = st_q.tmr + 32'h1;
				end
				default:
				begin
					st_d.mode = LSC_IDLE;
					st_d.tmr = '0;
				end
			endcase
		end
	end

	always_ff @(posedge clk_sys)
	begin
		if (rst)
		begin
			st_q.mode <= LSC_IDLE;
			st_q.tmr <= '0;
			st_q.level <= `LSC_RST_CNT;
		end
		else
			st_q <= st_d;
	end

endmodule : lsc_step_seq

//--- hw/lsc_top.sv
// Load step controller: ballast steps for light load, shedding steps for
// heavy load. Assumes load_kw and sequencer flags are synchronous to clk_sys.
`timescale 1ns/1ps
`include "lsc_map.svh"

// Behaviour
// - Up to five ballast step outputs, count set by configuration.
// - On start, all ballast outputs are held off.
// - Ballast supervision only runs while the generator is on load.
// - Load below ballast trip level starts the ballast trip timer.
// - Trip delay elapsed below level energises the next ballast step.
// - Monitoring repeats, adding steps until all configured are on.
// - Load above ballast return level starts the ballast return timer.
// - Return delay elapsed drops highest ballast step, repeating until none.
// - Stopping entry drops all steps in the load switch open cycle.
// - Up to five shedding step outputs, count set by configuration.
// - Initial shedding count energises in the same cycle as the load switch close command.
// - On load, load above shed trip level starts shed trip timer.
// - Trip delay elapsed above level energises the next shed step.
// - Each further full trip period energises the next shed step.
// - Load below shed return level starts the shed return timer.
// - Return delay elapsed drops the highest shed step, repeating.
module lsc_top
	import lsc_pkg::*;
#(
	parameter int NSTEP = `LSC_MAX_STEPS
)(
	input wire logic clk_sys,
	input wire logic rst,
	input wire logic [7:0] reg_addr,
	input wire logic [31:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [31:0] reg_rdata,
	input wire logic [`LSC_KW_W-1:0] load_kw,
	input wire logic gen_start,
	input wire logic load_request,
	input wire logic stop_entry,
	output logic load_close,
	output logic load_open,
	output logic [NSTEP-1:0] ballast_out,
	output logic [NSTEP-1:0] shed_out
);

	// ****************************************************************
	// State
	// ****************************************************************
	typedef struct packed {
		lsc_cnt_t bal_cnt;
		lsc_cnt_t shd_cnt;
		lsc_cnt_t initial_shed_count;
		lsc_kw_t bal_trip;
		lsc_kw_t bal_ret;
		lsc_dly_t bal_tdly;
		lsc_dly_t bal_rdly;
		lsc_kw_t shd_trip;
		lsc_kw_t shd_ret;
		lsc_dly_t shd_tdly;
		lsc_dly_t shd_rdly;
		logic on_load;
		logic close_pend;
		logic load_close;
		logic load_open;
		logic [NSTEP-1:0] bal_out;
		logic [NSTEP-1:0] shd_out;
		logic [31:0] rdata;
	} lsc_st_t;

	lsc_st_t st_q;
	lsc_st_t st_d;

	lsc_step_if bal_if ();
	lsc_step_if shd_if ();
	logic [NSTEP-1:0] bal_dec;
	logic [NSTEP-1:0] shd_dec;

	// ****************************************************************
	// Step sequencers
	// ****************************************************************
	always_comb
	begin
		bal_if.run = st_q.on_load;
		bal_if.clear = gen_start || stop_entry;
		bal_if.preset = 1'b0;
		bal_if.preset_cnt = '0;
		bal_if.max_cnt = st_q.bal_cnt;
		bal_if.trip_cond = load_kw < st_q.bal_trip;
		bal_if.ret_cond = load_kw > st_q.bal_ret;
		bal_if.trip_dly = st_q.bal_tdly;
		bal_if.ret_dly = st_q.bal_rdly;
		shd_if.run = st_q.on_load;
		shd_if.clear = stop_entry;
		// Shed the initial steps as the close is requested
		shd_if.preset = load_request && !st_q.on_load && !st_q.close_pend
			&& !stop_entry;
		shd_if.preset_cnt = st_q.initial_shed_count;
		shd_if.max_cnt = st_q.shd_cnt;
		shd_if.trip_cond = load_kw > st_q.shd_trip;
		shd_if.ret_cond = load_kw < st_q.shd_ret;
		shd_if.trip_dly = st_q.shd_tdly;
		shd_if.ret_dly = st_q.shd_rdly;
	end

	lsc_step_seq u_bal (
		.clk_sys(clk_sys),
		.rst(rst),
		.s(bal_if.seq)
	);

	lsc_step_seq u_shd (
		.clk_sys(clk_sys),
		.rst(rst),
		.s(shd_if.seq)
	);

	// Thermometer decode of the step level
	genvar gi;
	generate
		for (gi = 0; gi < NSTEP; gi++)
		begin : g_dec
			assign bal_dec[gi] = (32'(bal_if.level) > gi)
				&& (32'(st_q.bal_cnt) > gi);
			assign shd_dec[gi] = (32'(shd_if.level) > gi)
				&& (32'(st_q.shd_cnt) > gi);
		end
	endgenerate

	// ****************************************************************
	// Next state
	// ****************************************************************
	function automatic lsc_cnt_t clip(input logic [31:0] v);
		lsc_cnt_t r;
		r = (v[`LSC_CNT_W-1:0] > lsc_cnt_t'(NSTEP))
			? lsc_cnt_t'(NSTEP) : v[`LSC_CNT_W-1:0];
		return r;
	endfunction : clip

	always_comb
	begin
		st_d = st_q;
		st_d.rdata = '0;
		st_d.load_open = 1'b0;
		st_d.load_close = 1'b0;
		if (reg_wr)
		begin
			case (reg_addr)
				`LSC_A_CTRL:
				begin
					st_d.bal_cnt = clip(reg_wdata >> `LSC_CTRL_BAL_CNT_LSB);
					st_d.shd_cnt = clip(reg_wdata >> `LSC_CTRL_SHD_CNT_LSB);
					st_d.initial_shed_count =
						clip(reg_wdata >> `LSC_CTRL_INIT_CNT_LSB);
				end
				`LSC_A_BAL_TRIP: st_d.bal_trip = reg_wdata[`LSC_KW_W-1:0];
				`LSC_A_BAL_RET: st_d.bal_ret = reg_wdata[`LSC_KW_W-1:0];
				`LSC_A_BAL_TDLY: st_d.bal_tdly = reg_wdata;
				`LSC_A_BAL_RDLY: st_d.bal_rdly = reg_wdata;
				`LSC_A_SHD_TRIP: st_d.shd_trip = reg_wdata[`LSC_KW_W-1:0];
				`LSC_A_SHD_RET: st_d.shd_ret = reg_wdata[`LSC_KW_W-1:0];
				`LSC_A_SHD_TDLY: st_d.shd_tdly = reg_wdata;
				`LSC_A_SHD_RDLY: st_d.shd_rdly = reg_wdata;
				default: st_d.bal_cnt = st_q.bal_cnt;
			endcase
		end
		if (reg_rd)
		begin
			case (reg_addr)
				`LSC_A_CTRL:
					st_d.rdata = 32'({st_q.initial_shed_count, 1'b0,
						st_q.shd_cnt, 1'b0, st_q.bal_cnt});
				`LSC_A_BAL_TRIP: st_d.rdata = 32'(st_q.bal_trip);
				`LSC_A_BAL_RET: st_d.rdata = 32'(st_q.bal_ret);
				`LSC_A_BAL_TDLY: st_d.rdata = st_q.bal_tdly;
				`LSC_A_BAL_RDLY: st_d.rdata = st_q.bal_rdly;
				`LSC_A_SHD_TRIP: st_d.rdata = 32'(st_q.shd_trip);
				`LSC_A_SHD_RET: st_d.rdata = 32'(st_q.shd_ret);
				`LSC_A_SHD_TDLY: st_d.rdata = st_q.shd_tdly;
				`LSC_A_SHD_RDLY: st_d.rdata = st_q.shd_rdly;
				`LSC_A_STATUS:
				begin
					st_d.rdata[`LSC_ST_BAL_LSB +: NSTEP] = st_q.bal_out;
					st_d.rdata[`LSC_ST_SHD_LSB +: NSTEP] = st_q.shd_out;
					st_d.rdata[`LSC_ST_ON_LOAD_BIT] = st_q.on_load;
				end
				default: st_d.rdata = '0;
			endcase
		end

		// Load switch sequencing: shed preset first, close and shed outputs one cycle later
		if (stop_entry)
		begin
			st_d.on_load = 1'b0;
			st_d.close_pend = 1'b0;
			st_d.load_open = 1'b1;
		end
		else if (shd_if.preset)
			st_d.close_pend = 1'b1;
		else if (st_q.close_pend)
		begin
			st_d.close_pend = 1'b0;
			st_d.load_close = 1'b1;
			st_d.on_load = 1'b1;
		end
		if (gen_start && !st_q.on_load)
			st_d.close_pend = st_d.close_pend;

		// Outputs forced low in the same edge as the open command
		st_d.bal_out = stop_entry ? '0 : bal_dec;
		st_d.shd_out = stop_entry ? '0 : shd_dec;
	end

	always_ff @(posedge clk_sys)
	begin
		if (rst)
		begin
			st_q.bal_cnt <= lsc_cnt_t'(NSTEP);
			st_q.shd_cnt <= lsc_cnt_t'(NSTEP);
			st_q.initial_shed_count <= `LSC_RST_CNT;
			st_q.bal_trip <= `LSC_RST_KW;
			st_q.bal_ret <= `LSC_RST_KW;
			st_q.bal_tdly <= `LSC_RST_DLY;
			st_q.bal_rdly <= `LSC_RST_DLY;
			st_q.shd_trip <= `LSC_RST_KW;
			st_q.shd_ret <= `LSC_RST_KW;
			st_q.shd_tdly <= `LSC_RST_DLY;
			st_q.shd_rdly <= `LSC_RST_DLY;
			st_q.on_load <= 1'b0;
			st_q.close_pend <= 1'b0;
			st_q.load_close <= 1'b0;
			st_q.load_open <= 1'b0;
			st_q.bal_out <= '0;
			st_q.shd_out <= '0;
			st_q.rdata <= '0;
		end
		else
			st_q <= st_d;
	end

	assign reg_rdata = st_q.rdata;
	assign load_close = st_q.load_close;
	assign load_open = st_q.load_open;
	assign ballast_out = st_q.bal_out;
	assign shed_out = st_q.shd_out;

endmodule : lsc_top

//--- tb/lsc_gen_model.sv
// External load switch: follows the close and open command pulses.
// Assumes pulses synchronous to clk_sys.
`timescale 1ns/1ps

module lsc_gen_model (
	input wire logic clk_sys,
	input wire logic rst,
	input wire logic load_close,
	input wire logic load_open,
	output logic sw_closed
);
	// Open wins if both come together, the safe way round
	always @(posedge clk_sys)
	begin
		if (rst || load_open)
			sw_closed <= 1'h0;
		else if (load_close)
			sw_closed <= 1'h1;
	end
endmodule : lsc_gen_model

//--- tb/lsc_top_checker.sv
// Port checks on the load step controller.
// Assumes one clock domain; bound to lsc_top at the foot of this file.
`timescale 1ns/1ps

module lsc_top_checker #(
	parameter int NSTEP = 5
)(
	input wire logic clk_sys,
	input wire logic rst,
	input wire logic gen_start,
	input wire logic load_request,
	input wire logic stop_entry,
	input wire logic load_close,
	input wire logic load_open,
	input wire logic [NSTEP-1:0] ballast_out,
	input wire logic [NSTEP-1:0] shed_out
);
	// ****************************************************************
	// Switch state
	// ****************************************************************
	// On load is not a port, so it is rebuilt from the two pulses
	logic on_q;
	logic on_d;
	always_comb
	begin
		on_d = on_q;
		if (load_close)
			on_d = 1'h1;
		if (load_open)
			on_d = 1'h0;
	end
	always_ff @(posedge clk_sys)
	begin
		if (rst)
			on_q <= 1'h0;
		else
			on_q <= on_d;
	end

	// ****************************************************************
	// Assertions
	// ****************************************************************
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (rst);

	stop_clear_a:
		assert property (load_open |-> ballast_out == '0 && shed_out == '0)
		else $error("steps still on at switch open");
	open_follow_a:
		assert property (stop_entry |=> load_open)
		else $error("no open pulse after stop entry");
	bal_order_a:
		assert property (((ballast_out + 1'h1) & ballast_out) == '0)
		else $error("ballast steps not contiguous");
	shed_order_a:
		assert property (((shed_out + 1'h1) & shed_out) == '0)
		else $error("shed steps not contiguous");
	bal_single_a:
		assert property ($countones(ballast_out) <=
			$countones($past(ballast_out)) + 1)
		else $error("more than one ballast step added");
	bal_offload_a:
		assert property (!on_q && !load_close |=>
			$countones(ballast_out) <= $countones($past(ballast_out)))
		else $error("ballast step added off load");
	shed_offload_a:
		assert property (!on_q && !load_close |=> load_close ||
			$countones(shed_out) <= $countones($past(shed_out)))
		else $error("shed step added off load");
	close_req_a:
		assert property (load_close |-> $past(load_request, 2))
		else $error("close without request");
	close_pulse_a:
		assert property (load_close |=> !load_close)
		else $error("close pulse too long");
	start_clear_a:
		assert property (gen_start |-> ##[1:2] ballast_out == '0)
		else $error("ballast not cleared on start");
endmodule : lsc_top_checker

bind lsc_top lsc_top_checker #(.NSTEP(NSTEP)) u_chk (
	.clk_sys(clk_sys),
	.rst(rst),
	.gen_start(gen_start),
	.load_request(load_request),
	.stop_entry(stop_entry),
	.load_close(load_close),
	.load_open(load_open),
	.ballast_out(ballast_out),
	.shed_out(shed_out)
);

//--- tb/lsc_top_tb.sv
// Testbench for the load step controller.
// Assumes the checker is bound by its own file.
`timescale 1ns/1ps

module lsc_top_tb;
	logic clk_sys = 1'h0;
	logic rst = 1'h1;
	logic [7:0] reg_addr = 8'h00;
	logic [31:0] reg_wdata = 32'h0;
	logic reg_wr = 1'h0;
	logic reg_rd = 1'h0;
	logic [31:0] reg_rdata;
	logic [15:0] load_kw = 16'h00fa;
	logic gen_start = 1'h0;
	logic load_request = 1'h0;
	logic stop_entry = 1'h0;
	logic load_close;
	logic load_open;
	logic sw_closed;
	logic [4:0] ballast_out;
	logic [4:0] shed_out;
	int n_errors = 0;
	int checks = 0;
	// Levels keep a dead band so each phase moves one group, except 16'h000a which moves both
	logic [31:0] cfg [0:8] = '{32'h253, 32'h64, 32'h12c, 32'h14, 32'h14,
		32'h384, 32'h1e, 32'h14, 32'h14};

	always #2 clk_sys = ~clk_sys;

	lsc_top #(.NSTEP(5)) u_dut (
		.clk_sys(clk_sys),
		.rst(rst),
		.reg_addr(reg_addr),
		.reg_wdata(reg_wdata),
		.reg_wr(reg_wr),
		.reg_rd(reg_rd),
		.reg_rdata(reg_rdata),
		.load_kw(load_kw),
		.gen_start(gen_start),
		.load_request(load_request),
		.stop_entry(stop_entry),
		.load_close(load_close),
		.load_open(load_open),
		.ballast_out(ballast_out),
		.shed_out(shed_out)
	);

	lsc_gen_model u_sw (
		.clk_sys(clk_sys),
		.rst(rst),
		.load_close(load_close),
		.load_open(load_open),
		.sw_closed(sw_closed)
	);

	// ****************************************************************
	// Tasks
	// ****************************************************************
	task automatic summarize;
		if (n_errors == 0 && checks > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask : summarize

	task automatic chk(input string nm, input logic [31:0] seen,
		input logic [31:0] exp);
		checks++;
		if (seen !== exp)
		begin
			n_errors++;
			$display("wrong value %s expected %h seen %h", nm, exp, seen);
		end
	endtask : chk

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk_sys);
		reg_wr <= 1'h1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge clk_sys);
		reg_wr <= 1'h0;
	endtask : wr

	task automatic rd(input string nm, input logic [7:0] a,
		input logic [31:0] exp);
		@(posedge clk_sys);
		reg_rd <= 1'h1;
		reg_addr <= a;
		@(posedge clk_sys);
		reg_rd <= 1'h0;
		#1;
		chk(nm, reg_rdata, exp);
	endtask : rd

	task automatic step(input logic [15:0] kw, input int n);
		@(posedge clk_sys);
		load_kw <= kw;
		repeat (n) @(posedge clk_sys);
		#1;
	endtask : step

	// ****************************************************************
	// Tests
	// ****************************************************************
	initial
	begin
		repeat (20) @(posedge clk_sys);
		rst <= 1'h0;
		chk("ballast", ballast_out, 32'h0);
		rd("ctrl", 8'h00, 32'h55);
		rd("unmapped", 8'h40, 32'h0);
		wr(8'h00, 32'h0000_0777);
		rd("ctrl", 8'h00, 32'h555);
		for (int i = 0; i < 9; i++)
			wr(8'(4 * i), cfg[i]);
		wr(8'h24, 32'hffff_ffff);
		rd("status", 8'h24, 32'h0);
		rd("ctrl", 8'h00, 32'h253);
		@(posedge clk_sys);
		gen_start <= 1'h1;
		@(posedge clk_sys);
		gen_start <= 1'h0;
		step(16'h0032, 60);
		chk("ballast", ballast_out, 32'h0);
		step(16'h00fa, 2);
		@(posedge clk_sys);
		load_request <= 1'h1;
		@(posedge clk_sys);
		load_request <= 1'h0;
		repeat (8)
		begin
			@(posedge clk_sys);
			#1;
			if (load_close === 1'h1)
				break;
		end
		chk("load_close", load_close, 32'h1);
		chk("shed", shed_out, 32'h3);
		step(16'h0032, 10);
		step(16'h00fa, 10);
		step(16'h0032, 10);
		step(16'h00fa, 5);
		chk("ballast", ballast_out, 32'h0);
		step(16'h0032, 30);
		chk("ballast", ballast_out, 32'h1);
		step(16'h0032, 20);
		chk("ballast", ballast_out, 32'h3);
		step(16'h0032, 100);
		chk("ballast", ballast_out, 32'h7);
		rd("status", 8'h24, 32'h0001_0307);
		step(16'h0190, 30);
		chk("ballast", ballast_out, 32'h3);
		step(16'h0190, 80);
		chk("ballast", ballast_out, 32'h0);
		step(16'h03e8, 30);
		chk("shed", shed_out, 32'h7);
		step(16'h03e8, 90);
		chk("shed", shed_out, 32'h1f);
		step(16'h000a, 30);
		chk("shed", shed_out, 32'hf);
		chk("ballast", ballast_out, 32'h1);
		chk("sw_closed", sw_closed, 32'h1);
		// A fresh start must drop a ballast step that is already on
		@(posedge clk_sys);
		gen_start <= 1'h1;
		@(posedge clk_sys);
		gen_start <= 1'h0;
		@(posedge clk_sys);
		#1;
		chk("ballast", ballast_out, 32'h0);
		@(posedge clk_sys);
		stop_entry <= 1'h1;
		@(posedge clk_sys);
		stop_entry <= 1'h0;
		#1;
		chk("load_open", load_open, 32'h1);
		chk("steps", {ballast_out, shed_out}, 32'h0);
		rd("status", 8'h24, 32'h0);
		chk("sw_closed", sw_closed, 32'h0);
		summarize();
	end

	// Whole sequence is under 1000 cycles
	initial
	begin
		repeat (3000) @(posedge clk_sys);
		n_errors++;
		summarize();
	end
endmodule : lsc_top_tb
